//--- core/file_op_pkg.sv
// Purpose: shared constants and carriers for the file-register exec block
// Assumes: 14-bit instruction words, 8-bit data, 7-bit file address
// Notes: opcode field is instr[13:8]; destination bit is instr[7]
package file_op_pkg;

  localparam int INSTR_W = 14;
  localparam int DATA_W = 8;
  localparam int FADDR_W = 7;
  localparam int OPC_MSB = 13;
  localparam int OPC_LSB = 8;
  localparam int DEST_POS = 7;
  localparam logic [5:0] OPC_DECREMENT = 6'h03;
  localparam logic [5:0] OPC_INVERT = 6'h09;
  localparam logic [5:0] OPC_DEC_SKIP = 6'h0b;
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
  localparam logic [FADDR_W-1:0] FADDR_RST = 7'h00;
  localparam logic DEST_ACC = 1'b0;
  localparam logic DEST_FILE = 1'b1;

  typedef enum logic [1:0] {
    OP_NONE = 2'b00,
    OP_FILE_DECREMENT = 2'b01,
    OP_FILE_INVERT = 2'b10,
    OP_DECREMENT_SKIP_ZERO = 2'b11
  } op_kind_t;

  // one instruction slot from fetch, with the operand already read
  typedef struct packed {
    logic valid;
    logic [INSTR_W-1:0] instr;
    logic [DATA_W-1:0] file_data;
  } issue_t;

  // result headed for the accumulator or the data memory
  typedef struct packed {
    logic acc_we;
    logic file_we;
    logic [FADDR_W-1:0] file_addr;
    logic [DATA_W-1:0] data;
    logic zero_we;
    logic zero_val;
  } result_t;

endpackage

//--- core/file_op_decode.sv
// Purpose: classify one instruction word for the file exec block
// Assumes: combinational, no state
// Notes: words outside the three handled opcodes give OP_NONE
`timescale 1ns/1ps
module file_op_decode (
  // instruction in
  input wire logic [file_op_pkg::INSTR_W-1:0] instr,
  // decoded fields
  output file_op_pkg::op_kind_t kind,
  output logic dest,
  output logic [file_op_pkg::FADDR_W-1:0] faddr
);
  import file_op_pkg::*;

  always_comb begin
    unique case (instr[OPC_MSB:OPC_LSB])
      OPC_DECREMENT: kind = OP_FILE_DECREMENT;
      OPC_INVERT: kind = OP_FILE_INVERT;
      OPC_DEC_SKIP: kind = OP_DECREMENT_SKIP_ZERO;
      default: kind = OP_NONE;
    endcase
    dest = instr[DEST_POS];
    faddr = instr[FADDR_W-1:0];
  end

endmodule

//--- core/file_reg_dec_comp_exec.sv
// What this block does
// - decrement file, route by dest, set Z
// - opcode 001001 inverts file, sets Z
// - invert: dest 0 to acc, 1 to file
// - opcode 001011 decrements, flags left alone
// - skip-decrement: dest 0 acc, 1 file
// - zero result discards the prefetched instruction
// - idle cycle replaces it; 1 or 2 cycles
//
// Purpose: execute decrement, invert and decrement-skip on file registers
// Assumes: one issue slot per instruction cycle, operand read alongside
// Notes: results appear one REF_CLK edge after the issue slot
//   a zero skip swallows only the next valid slot; an empty slot
//   in between lets the discard lapse, as the fetch path expects
//   reset clears a pending discard along with every output
`timescale 1ns/1ps
module file_reg_dec_comp_exec #(
  parameter int DATA_WIDTH = file_op_pkg::DATA_W
) (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic ARST_N,
  // issue slot from fetch and operand read
  input file_op_pkg::issue_t ISSUE,
  // result toward accumulator, memory and status
  output file_op_pkg::result_t RESULT,
  // fetch path: prefetched word is dropped this cycle
  output logic FLUSH,
  output logic IDLE_CYCLE
);
  import file_op_pkg::*;

  // layout checks: the decoder slices fixed fields of the word
  if (DATA_WIDTH != DATA_W) begin : g_bad_data_width
    $error("DATA_WIDTH must equal the package data width");
  end
  if (OPC_MSB != INSTR_W - 1) begin : g_bad_opc_msb
    $error("opcode field must end at the top of the word");
  end
  if (OPC_LSB != DEST_POS + 1) begin : g_bad_opc_lsb
    $error("opcode field must sit just above the destination bit");
  end
  if (DEST_POS != FADDR_W) begin : g_bad_dest_pos
    $error("destination bit must sit just above the file address");
  end
  if (OPC_MSB - OPC_LSB != 5) begin : g_bad_opc_width
    $error("opcode field must be six bits wide");
  end
  if (OPC_DECREMENT == OPC_INVERT || OPC_INVERT == OPC_DEC_SKIP ||
      OPC_DECREMENT == OPC_DEC_SKIP) begin : g_bad_opc_codes
    $error("the three handled opcodes must differ");
  end

  // one slot after the discard decision
  typedef struct packed {
    logic taken;
    logic discarded;
    op_kind_t kind;
    logic dest;
    logic [FADDR_W-1:0] faddr;
  } slot_t;

  typedef struct packed {
    result_t res;
    logic flush;
    logic idle;
  } state_t;

  // zero test, shared by both flag updates and the skip decision
  function automatic logic is_zero(input logic [DATA_W-1:0] v);
    return (v == '0);
  endfunction

  // destination bit to {accumulator, file} write enables
  function automatic logic [1:0] dest_we(input logic d);
    return {d == DEST_ACC, d == DEST_FILE};
  endfunction

  // plain write-back of a value, no flag and no skip yet
  function automatic result_t write_back(
    input logic d,
    input logic [FADDR_W-1:0] a,
    input logic [DATA_W-1:0] v
  );
    result_t r;
    r = '0;
    {r.acc_we, r.file_we} = dest_we(d);
    r.file_addr = a;
    r.data = v;
    return r;
  endfunction

  // decrement: write back, Z from the result
  function automatic state_t exec_decrement(
    input logic d,
    input logic [FADDR_W-1:0] a,
    input logic [DATA_W-1:0] v
  );
    state_t s;
    s = '0;
    s.res = write_back(d, a, v);
    s.res.zero_we = 1'b1;
    s.res.zero_val = is_zero(v);
    s.flush = 1'b0;
    return s;
  endfunction

  // invert: write back, Z from the result
  function automatic state_t exec_invert(
    input logic d,
    input logic [FADDR_W-1:0] a,
    input logic [DATA_W-1:0] v
  );
    state_t s;
    s = '0;
    s.res = write_back(d, a, v);
    s.res.zero_we = 1'b1;
    s.res.zero_val = is_zero(v);
    s.flush = 1'b0;
    return s;
  endfunction

  // decrement-skip: status flags stay as they are
  function automatic state_t exec_dec_skip(
    input logic d,
    input logic [FADDR_W-1:0] a,
    input logic [DATA_W-1:0] v
  );
    state_t s;
    s = '0;
    s.res = write_back(d, a, v);
    s.res.zero_we = 1'b0;
    // zero result drops the prefetched word
    s.flush = is_zero(v);
    return s;
  endfunction

  // the dropped word becomes an idle cycle, nothing written
  function automatic state_t exec_idle(input logic [FADDR_W-1:0] a);
    state_t s;
    s = '0;
    s.res.file_addr = a;
    s.idle = 1'b1;
    return s;
  endfunction

  state_t st_reg;
  state_t st_next;
  slot_t slot;
  op_kind_t kind;
  logic dest;
  logic [FADDR_W-1:0] faddr;
  logic [DATA_W-1:0] dec_val;
  wire [DATA_W-1:0] inv_val;

  file_op_decode u_dec (
    .instr(ISSUE.instr),
    .kind(kind),
    .dest(dest),
    .faddr(faddr)
  );

  // minus one wraps 00 to ff, so only 01 ends a skip loop
  assign dec_val = ISSUE.file_data - 8'h01;

  // per-bit inversion, one gate per result bit
  for (genvar i = 0; i < DATA_W; i++) begin : g_invert
    assign inv_val[i] = ~ISSUE.file_data[i];
  end

  // slot acceptance decided before any instruction looks at it
  always_comb begin
    slot = '0;
    slot.kind = kind;
    slot.dest = dest;
    slot.faddr = faddr;
    // prefetched word after a zero skip
    slot.discarded = ISSUE.valid && st_reg.flush;
    slot.taken = ISSUE.valid && !st_reg.flush;
  end

  always_comb begin
    st_next = '0;
    // address follows the slot even when nothing is written
    st_next.res.file_addr = slot.faddr;
    if (slot.discarded) begin
      st_next = exec_idle(slot.faddr);
    end else if (slot.taken) begin
      unique case (slot.kind)
        OP_FILE_DECREMENT: begin
          st_next = exec_decrement(slot.dest, slot.faddr, dec_val);
        end
        OP_FILE_INVERT: begin
          st_next = exec_invert(slot.dest, slot.faddr, inv_val);
        end
        OP_DECREMENT_SKIP_ZERO: begin
          st_next = exec_dec_skip(slot.dest, slot.faddr, dec_val);
        end
        OP_NONE: begin
          // unhandled opcodes write nothing and never skip
          st_next.flush = 1'b0;
        end
      endcase
    end
  end

  // a discard still pending at reset is forgotten with the rest
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign RESULT = st_reg.res;
  assign FLUSH = st_reg.flush;
  assign IDLE_CYCLE = st_reg.idle;

endmodule

//--- bench/file_exec_monitor.sv
// Purpose: port checks. Assumes: one clock. Notes: bind below.
`timescale 1ns/1ps
module file_exec_monitor (
  // clock, reset
  input wire logic REF_CLK,
  input wire logic ARST_N,
  // slot, result
  input file_op_pkg::issue_t ISSUE,
  input file_op_pkg::result_t RESULT,
  input wire logic FLUSH,
  input wire logic IDLE_CYCLE
);
  import file_op_pkg::*;
  // a flushed slot never counts as taken
  wire t = ISSUE.valid & ~FLUSH;
  wire [5:0] o = ISSUE.instr[13:8];
  wire [1:0] w = {~ISSUE.instr[7], ISSUE.instr[7]};
  wire [1:0] q = {RESULT.acc_we, RESULT.file_we};
  wire [7:0] f = ISSUE.file_data;
  wire [7:0] m = f - 8'h01;
  wire [7:0] y = RESULT.data;
  wire z = RESULT.zero_we;
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!ARST_N);
  property p_dec; t&&o==6'h03 |=> z&&y==$past(m)&&q==$past(w)
    &&RESULT.zero_val==($past(m)==8'h00); endproperty
  a_dec: assert property(p_dec) else $error("dec");
  property p_inv; t&&o==6'h09 |=> z&&y==~$past(f)
    &&RESULT.zero_val==($past(f)==8'hff); endproperty
  a_inv: assert property(p_inv) else $error("inv");
  property p_idst; t&&o==6'h09 |=> q==$past(w); endproperty
  a_idst: assert property(p_idst) else $error("idst");
  property p_keep; t&&o==6'h0b |=> !z&&y==$past(m); endproperty
  a_keep: assert property(p_keep) else $error("keep");
  property p_sdst; t&&o==6'h0b |=> q==$past(w); endproperty
  a_sdst: assert property(p_sdst) else $error("sdst");
  property p_skip; t&&o==6'h0b |=> FLUSH==($past(m)==8'h00); endproperty
  a_skip: assert property(p_skip) else $error("skip");
  property p_idle; FLUSH&&ISSUE.valid |=> IDLE_CYCLE&&q==2'h0
    &&!z&&!FLUSH; endproperty
  a_idle: assert property(p_idle) else $error("idle");
  property p_one; t&&(o==6'h03||o==6'h09) |=> !FLUSH; endproperty
  a_one: assert property(p_one) else $error("one");
endmodule
bind file_reg_dec_comp_exec file_exec_monitor u_mon (
  .REF_CLK(REF_CLK),
  .ARST_N(ARST_N),
  .ISSUE(ISSUE),
  .RESULT(RESULT),
  .FLUSH(FLUSH),
  .IDLE_CYCLE(IDLE_CYCLE)
);

//--- bench/testbench.sv
// Purpose: bench. Assumes: answer one edge on. Notes: rows, then skip.
`timescale 1ns/1ps
module testbench;
  import file_op_pkg::*;
  logic clk = 1'h0, rst_n = 1'h0, flush, idle;
  issue_t s = '0;
  result_t r;
  int miscompares = 0, check_count = 0, cyc = 0;
  wire [20:0] seen = {r, flush, idle};
  // slot word, operand, then result with flush and idle
  logic [42:0] rows [6] = '{{14'h0381, 8'h01, 21'h8100c},
    {14'h0913, 8'h13, 21'h113ec8}, {14'h0b03, 8'h00, 21'h103ff0},
    {14'h0a81, 8'h01, 21'h01000}, {14'h09ff, 8'hff, 21'hff00c},
    {14'h0302, 8'h80, 21'h1027f8}};
  file_reg_dec_comp_exec uut (.REF_CLK(clk), .ARST_N(rst_n),
    .ISSUE(s), .RESULT(r), .FLUSH(flush), .IDLE_CYCLE(idle));
  task automatic chk(string n, logic [20:0] v, e);
    check_count++;
    if (v !== e) begin
      miscompares++;
      $display("BAD %s exp %h got %h", n, e, v);
    end
  endtask
  task automatic finish_test;
    if (miscompares == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // all-zero word drops valid, so put('0) ends a slot
  task automatic put(logic [21:0] w);
    @(posedge clk);
    s <= {|w, w};
    #1;
  endtask
  initial forever #5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 300) begin
      miscompares++;
      finish_test;
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'h1;
    foreach (rows[k]) begin
      put(rows[k][42:21]);
      put('0);
      chk("row", seen, rows[k][20:0]);
    end
    put({14'h0b84, 8'h01});
    put({14'h0384, 8'h10});
    chk("skip", seen, 21'h84002);
    put({14'h0984, 8'h0f});
    chk("idle", 21'({r.acc_we, r.file_we, idle}), 21'h1);
    put('0);
    chk("next", seen, 21'h84f08);
    // reset with a discard pending: the next slot must still run
    put({14'h0b84, 8'h01});
    @(posedge clk);
    rst_n <= 1'h0;
    s <= '0;
    #1;
    chk("rst", seen, 21'h0);
    repeat (2) @(posedge clk);
    rst_n <= 1'h1;
    s <= {1'h1, 14'h0384, 8'h10};
    put('0);
    chk("after", seen, 21'h840f8);
    finish_test;
  end
endmodule
